// ==== hw/timer8_pkg.sv ====
// constants shared by the 8-bit timer: addresses, field positions, resets, codes
package timer8_pkg;
  // clock select addresses, unit 6 and unit 7
  localparam logic [31:0] ADDR_CLK_LOW_U6 = 32'hFFFFF284;
  localparam logic [31:0] ADDR_CLK_HIGH_U6 = 32'hFFFFF28E;
  localparam logic [31:0] ADDR_CLK_LOW_U7 = 32'hFFFFF294;
  localparam logic [31:0] ADDR_CLK_HIGH_U7 = 32'hFFFFF29E;
  // mode control, compare and count addresses
  localparam logic [31:0] ADDR_COUNT_U6 = 32'hFFFFF280;
  localparam logic [31:0] ADDR_COMPARE_U6 = 32'hFFFFF282;
  localparam logic [31:0] ADDR_MODE_U6 = 32'hFFFFF286;
  localparam logic [31:0] ADDR_COUNT_U7 = 32'hFFFFF290;
  localparam logic [31:0] ADDR_COMPARE_U7 = 32'hFFFFF292;
  localparam logic [31:0] ADDR_MODE_U7 = 32'hFFFFF296;
  // reset values
  localparam logic [7:0] CLK_SELECT_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h04;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_WRAP = 8'hFF;
  // mode control field positions
  localparam int COUNT_ENABLE_BIT = 7;
  localparam int PWM_SELECT_BIT = 6;
  localparam int CASCADE_SELECT_BIT = 4;
  localparam int OUTPUT_PRESET_HIGH_BIT = 3;
  localparam int OUTPUT_PRESET_LOW_BIT = 2;
  localparam int ACTIVE_LEVEL_BIT = 1;
  localparam int OUTPUT_ENABLE_BIT = 0;
  // clock select fields: low register bits 2..0, high register bit 0
  localparam int CLOCK_LOW_MSB = 2;
  localparam int CLOCK_CODE_MSB_BIT = 0;
  // instance groups, each with its own special sources
  localparam logic [1:0] GROUP_PAIR_45 = 2'h0;
  localparam logic [1:0] GROUP_PAIR_67 = 2'h1;
  localparam logic [1:0] GROUP_PAIR_1011 = 2'h2;
  // count clock codes
  localparam logic [3:0] CODE_EVENT_FALL = 4'h0;
  localparam logic [3:0] CODE_EVENT_RISE = 4'h1;
  localparam logic [3:0] CODE_DIV4 = 4'h2;
  localparam logic [3:0] CODE_DIV8 = 4'h3;
  localparam logic [3:0] CODE_DIV16 = 4'h4;
  localparam logic [3:0] CODE_DIV32 = 4'h5;
  localparam logic [3:0] CODE_SIX = 4'h6;
  localparam logic [3:0] CODE_SEVEN = 4'h7;
  localparam logic [3:0] CODE_TEN = 4'hA;
  localparam logic [3:0] CODE_ELEVEN = 4'hB;
  localparam logic [3:0] CODE_SPECIAL = 4'hF;
  // prescaler width, enough for the /512 tap
  localparam int PRESCALE_BITS = 9;
endpackage

// ==== hw/timer8_pwm.sv ====
// 8-bit timer / event counter with compare, square wave and pwm output
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// pin filter: three flops, level follows once the second and third agree
module pin_edge_filter (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // raw pin
  input wire logic pin_in,
  // filtered edges
  output logic rise_out,
  output logic fall_out
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic level;
  logic level_prev;

  // only sync_b reads sync_a; the agreement test looks at b and c
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      level <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      level <= (sync_b == sync_c) ? sync_c : level;
      level_prev <= level;
    end
  end

  assign rise_out = level & ~level_prev;
  assign fall_out = ~level & level_prev;
endmodule

////////////////////////////////////////////////////////////////////////////////
// the timer itself
module timer8_pwm
  import timer8_pkg::*;
#(
  parameter logic [1:0] TIMER_GROUP = GROUP_PAIR_67,
  parameter logic [31:0] CLK_LOW_ADDR = ADDR_CLK_LOW_U6,
  parameter logic [31:0] CLK_HIGH_ADDR = ADDR_CLK_HIGH_U6,
  parameter logic [31:0] MODE_ADDR = ADDR_MODE_U6,
  parameter logic [31:0] COMPARE_ADDR = ADDR_COMPARE_U6,
  parameter logic [31:0] COUNT_ADDR = ADDR_COUNT_U6
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // register access
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // count sources from outside
  input wire logic event_pin_in,
  input wire logic sub_clock_in,
  input wire logic line_sync_comp_input_in,
  input wire logic reference_timer_zero_ovf_in,
  input wire logic cascade_tick_in,
  // results
  output logic match_interrupt_out,
  output logic overflow_out,
  output logic timer_output_pin_out
);
  logic [7:0] clock_select_low;
  logic [7:0] clock_select_high;
  logic [7:0] mode_control;
  logic [7:0] compare_value;
  logic [7:0] count_value;
  logic [PRESCALE_BITS-1:0] prescale;
  logic output_ff;
  logic pwm_active;
  logic [9:2] div_tick;
  logic src_tick;
  logic event_rise;
  logic event_fall;
  logic sub_rise;
  logic line_rise;

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_low = reg_write_in && (reg_addr_in == CLK_LOW_ADDR);
  wire wr_high = reg_write_in && (reg_addr_in == CLK_HIGH_ADDR);
  wire wr_mode = reg_write_in && (reg_addr_in == MODE_ADDR);
  wire wr_compare = reg_write_in && (reg_addr_in == COMPARE_ADDR);
  wire [7:0] read_sel = (reg_addr_in == CLK_LOW_ADDR) ? clock_select_low :
                        (reg_addr_in == CLK_HIGH_ADDR) ? clock_select_high :
                        (reg_addr_in == MODE_ADDR) ? mode_control :
                        (reg_addr_in == COMPARE_ADDR) ? compare_value :
                        (reg_addr_in == COUNT_ADDR) ? count_value : 8'h00;

  // mode control fields
  wire count_enable_bit = mode_control[COUNT_ENABLE_BIT];
  wire pwm_select_bit = mode_control[PWM_SELECT_BIT];
  wire cascade_select_bit = mode_control[CASCADE_SELECT_BIT];
  wire active_level_bit = mode_control[ACTIVE_LEVEL_BIT];
  wire output_enable_bit = mode_control[OUTPUT_ENABLE_BIT];
  wire preset_high = reg_wdata_in[OUTPUT_PRESET_HIGH_BIT] & ~reg_wdata_in[OUTPUT_PRESET_LOW_BIT];
  wire preset_low = ~reg_wdata_in[OUTPUT_PRESET_HIGH_BIT] & reg_wdata_in[OUTPUT_PRESET_LOW_BIT];

  // four-bit count clock code
  wire clock_code_msb = clock_select_high[CLOCK_CODE_MSB_BIT];
  wire [3:0] clock_code = {clock_code_msb, clock_select_low[CLOCK_LOW_MSB:0]};

  // registers: unused clock select bits are dropped so they read as zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      clock_select_low <= CLK_SELECT_RESET;
      clock_select_high <= CLK_SELECT_RESET;
      mode_control <= MODE_RESET;
      compare_value <= COMPARE_RESET;
      reg_rdata_out <= 8'h00;
    end else begin
      if (wr_low) begin
        clock_select_low <= {5'h00, reg_wdata_in[CLOCK_LOW_MSB:0]};
      end
      if (wr_high) begin
        clock_select_high <= {7'h00, reg_wdata_in[CLOCK_CODE_MSB_BIT]};
      end
      if (wr_mode) begin
        mode_control <= reg_wdata_in;
      end
      if (wr_compare) begin
        compare_value <= reg_wdata_in;
      end
      reg_rdata_out <= reg_read_in ? read_sel : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler; tap k fires once every 2^k cycles
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  for (genvar k = 2; k <= 9; k++) begin : g_taps
    assign div_tick[k] = &prescale[k-1:0];
  end

  // the three pin sources pass the three-flop filter; timer zero overflow and cascade tick go in unfiltered
  pin_edge_filter u_event (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(event_pin_in),
    .rise_out(event_rise),
    .fall_out(event_fall)
  );

  pin_edge_filter u_sub (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(sub_clock_in),
    .rise_out(sub_rise),
    .fall_out()
  );

  pin_edge_filter u_line (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(line_sync_comp_input_in),
    .rise_out(line_rise),
    .fall_out()
  );

  // source select; every prohibited code falls to the default and never ticks
  always_comb begin
    src_tick = 1'b0;
    case (clock_code)
      CODE_EVENT_FALL: src_tick = (TIMER_GROUP == GROUP_PAIR_45) & event_fall;
      CODE_EVENT_RISE: src_tick = (TIMER_GROUP == GROUP_PAIR_45) & event_rise;
      CODE_DIV4: src_tick = div_tick[2];
      CODE_DIV8: src_tick = div_tick[3];
      CODE_DIV16: src_tick = div_tick[4];
      CODE_DIV32: src_tick = div_tick[5];
      CODE_SIX: src_tick = (TIMER_GROUP == GROUP_PAIR_45) ? div_tick[7] : div_tick[6];
      CODE_SEVEN: src_tick = (TIMER_GROUP == GROUP_PAIR_45) ? sub_rise : div_tick[7];
      CODE_TEN: src_tick = (TIMER_GROUP == GROUP_PAIR_45) ? div_tick[6] : div_tick[8];
      CODE_ELEVEN: src_tick = (TIMER_GROUP == GROUP_PAIR_45) ? div_tick[8] : div_tick[9];
      CODE_SPECIAL: begin
        src_tick = (TIMER_GROUP == GROUP_PAIR_67) ? reference_timer_zero_ovf_in :
                   (TIMER_GROUP == GROUP_PAIR_1011) ? line_rise : 1'b0;
      end
      default: src_tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // count step and compare decode
  wire raw_tick = cascade_select_bit ? cascade_tick_in : src_tick;
  wire count_tick = count_enable_bit & raw_tick;
  wire at_match = (count_value == compare_value);
  wire at_wrap = (count_value == COUNT_WRAP);
  wire clear_match = count_tick & ~pwm_select_bit & at_match;
  wire [7:0] next_count = ~count_enable_bit ? COUNT_RESET :
                          ~count_tick ? count_value :
                          clear_match ? COUNT_RESET :
                          count_value + 8'h01;
  wire next_irq = clear_match & ~pwm_select_bit;
  wire next_output_ff = (wr_mode & preset_high) ? 1'b1 :
                        (wr_mode & preset_low) ? 1'b0 :
                        (clear_match & output_enable_bit) ? ~output_ff : output_ff;
  // overflow sets before match clears, so compare FFH gives a full-width pulse
  wire next_pwm_active = (~count_enable_bit | ~pwm_select_bit) ? 1'b0 :
                         (count_tick & at_wrap) ? 1'b1 :
                         (count_tick & at_match) ? 1'b0 : pwm_active;
  wire pwm_level = (output_enable_bit & pwm_active) ? active_level_bit : ~active_level_bit;
  wire next_pin = pwm_select_bit ? pwm_level : (output_enable_bit & output_ff);

  // counter, flip-flops and registered outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_value <= COUNT_RESET;
      output_ff <= 1'b0;
      pwm_active <= 1'b0;
      match_interrupt_out <= 1'b0;
      overflow_out <= 1'b0;
      timer_output_pin_out <= 1'b0;
    end else begin
      count_value <= next_count;
      output_ff <= next_output_ff;
      pwm_active <= next_pwm_active;
      match_interrupt_out <= next_irq;
      overflow_out <= count_tick & at_wrap & ~clear_match;
      timer_output_pin_out <= next_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mode_reset;
    @(posedge clk_sys_in) rst_in |=> (mode_control == MODE_RESET);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode control not 04H after reset");

  property p_clear_on_match;
    @(posedge clk_sys_in) disable iff (rst_in)
      (count_tick && !pwm_select_bit && at_match) |=>
      (count_value == COUNT_RESET) && match_interrupt_out;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("match did not clear and interrupt");

  property p_stop_clears;
    @(posedge clk_sys_in) disable iff (rst_in)
      !count_enable_bit |=> (count_value == COUNT_RESET);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("count not 00H while stopped");

  property p_no_irq_pwm;
    @(posedge clk_sys_in) disable iff (rst_in)
      $past(pwm_select_bit) |-> !match_interrupt_out;
  endproperty
  a_no_irq_pwm: assert property (p_no_irq_pwm) else $error("match interrupt in pwm mode");

  property p_toggle;
    @(posedge clk_sys_in) disable iff (rst_in)
      (clear_match && output_enable_bit && !wr_mode) |=> (output_ff != $past(output_ff));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output flip-flop did not invert");

  property p_preset_high;
    @(posedge clk_sys_in) disable iff (rst_in)
      (wr_mode && preset_high) |=> output_ff;
  endproperty
  a_preset_high: assert property (p_preset_high) else $error("preset high not applied");

  property p_pwm_stop_inactive;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pwm_select_bit && !count_enable_bit)[*2] |=>
      (timer_output_pin_out == !$past(active_level_bit));
  endproperty
  a_pwm_stop_inactive: assert property (p_pwm_stop_inactive) else $error("pwm output active after stop");

  property p_prohibited_holds;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!cascade_select_bit && ((clock_code == 4'h8) || (clock_code == 4'h9) ||
      (clock_code == 4'hC) || (clock_code == 4'hD) || (clock_code == 4'hE))) |-> !count_tick;
  endproperty
  a_prohibited_holds: assert property (p_prohibited_holds) else $error("prohibited code ticked");

  property p_cascade_source;
    @(posedge clk_sys_in) disable iff (rst_in)
      cascade_select_bit |-> (count_tick == (count_enable_bit && cascade_tick_in));
  endproperty
  a_cascade_source: assert property (p_cascade_source) else $error("cascade tick not used");

  property p_pwm_free_run;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pwm_select_bit && count_tick) |=> (count_value == $past(count_value) + 8'h01);
  endproperty
  a_pwm_free_run: assert property (p_pwm_free_run) else $error("pwm count did not run free");

  property p_pwm_wrap_active;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pwm_select_bit && count_enable_bit && count_tick && at_wrap) ##1
      (pwm_select_bit && count_enable_bit && output_enable_bit) |=>
      (timer_output_pin_out == $past(active_level_bit));
  endproperty
  a_pwm_wrap_active: assert property (p_pwm_wrap_active) else $error("pwm not active after wrap");
endmodule

// ==== bench/pin_partner.sv ====
// pin partner: event pin and sub clock sources driven toward the timer
`timescale 1ns/1ns
module pin_partner (
  // clock
  input wire logic clk_sys_in,
  // driven pins
  output logic event_pin_out,
  output logic sub_clock_out
);
  // both pins idle low; the sub clock stands still outside a burst
  initial begin
    event_pin_out = 1'b0;
    sub_clock_out = 1'b0;
  end
  // six cycles high, six low: wider than the three-flop pin filter needs
  task automatic burst(input int n, input logic use_sub);
    repeat (n) begin
      @(negedge clk_sys_in);
      if (use_sub) begin
        sub_clock_out = 1'b1;
      end else begin
        event_pin_out = 1'b1;
      end
      repeat (6) @(negedge clk_sys_in);
      sub_clock_out = 1'b0;
      event_pin_out = 1'b0;
      repeat (5) @(negedge clk_sys_in);
    end
  endtask
endmodule

// ==== bench/tb_top.sv ====
// bench top: register tasks, scenario sequence and verdict for the 8-bit timer
`timescale 1ns/1ns
module tb_top;
  import timer8_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] reg_addr_in = 32'h0;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic cascade_tick_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic match_interrupt_out, overflow_out, timer_output_pin_out, event_pin, sub_clock;
  logic pwm_watch = 1'b0;
  logic [7:0] rdata_ref, rdata_line;
  logic ref_ovf = 1'b0;
  logic line_sync = 1'b0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int irq_in_pwm = 0;
  int t0, t1;
  logic [3:0] codes [7] = '{CODE_DIV4, CODE_DIV8, CODE_DIV16, CODE_DIV32, CODE_SIX, CODE_TEN,
    CODE_ELEVEN};
  int divs [7] = '{4, 8, 16, 32, 128, 64, 256};

  ////////////////////////////////////////////////////////////////////////////
  // clock, cycle stamp and a watch for stray interrupts in pwm
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (pwm_watch && match_interrupt_out === 1'b1) begin
      irq_in_pwm <= irq_in_pwm + 1;
    end
  end

  // pair 4/5 is the only group with event pin and sub clock sources
  timer8_pwm #(.TIMER_GROUP(GROUP_PAIR_45)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .event_pin_in(event_pin), .sub_clock_in(sub_clock),
    .line_sync_comp_input_in(1'b0), .reference_timer_zero_ovf_in(1'b0),
    .cascade_tick_in(cascade_tick_in), .match_interrupt_out(match_interrupt_out),
    .overflow_out(overflow_out), .timer_output_pin_out(timer_output_pin_out));
  pin_partner i_pins (.clk_sys_in(clk_sys_in), .event_pin_out(event_pin),
    .sub_clock_out(sub_clock));
  // unit 7 twins share the unit 7 addresses; each must count only its own special source
  timer8_pwm #(.TIMER_GROUP(GROUP_PAIR_67), .CLK_LOW_ADDR(ADDR_CLK_LOW_U7),
    .CLK_HIGH_ADDR(ADDR_CLK_HIGH_U7), .MODE_ADDR(ADDR_MODE_U7),
    .COMPARE_ADDR(ADDR_COMPARE_U7), .COUNT_ADDR(ADDR_COUNT_U7)) i_dut_ref (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(rdata_ref), .event_pin_in(event_pin), .sub_clock_in(sub_clock),
    .line_sync_comp_input_in(line_sync), .reference_timer_zero_ovf_in(ref_ovf),
    .cascade_tick_in(1'b0), .match_interrupt_out(), .overflow_out(),
    .timer_output_pin_out());
  timer8_pwm #(.TIMER_GROUP(GROUP_PAIR_1011), .CLK_LOW_ADDR(ADDR_CLK_LOW_U7),
    .CLK_HIGH_ADDR(ADDR_CLK_HIGH_U7), .MODE_ADDR(ADDR_MODE_U7),
    .COMPARE_ADDR(ADDR_COMPARE_U7), .COUNT_ADDR(ADDR_COUNT_U7)) i_dut_line (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(rdata_line), .event_pin_in(event_pin), .sub_clock_in(sub_clock),
    .line_sync_comp_input_in(line_sync), .reference_timer_zero_ovf_in(ref_ovf),
    .cascade_tick_in(1'b0), .match_interrupt_out(), .overflow_out(),
    .timer_output_pin_out());

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and register access
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    @(negedge clk_sys_in);
    reg_write_in = 1'b0;
  endtask
  // read data is registered at the taking edge, so it is looked at one half cycle later
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_read_in = 1'b1;
    @(negedge clk_sys_in);
    reg_read_in = 1'b0;
    check({8'h00, reg_rdata_out}, {8'h00, exp});
  endtask
  // unit 7 read reaches both twins: line sync twin in the upper byte
  task automatic rd7_chk(input logic [31:0] a, input logic [15:0] exp);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_read_in = 1'b1;
    @(negedge clk_sys_in);
    reg_read_in = 1'b0;
    check({rdata_line, rdata_ref}, exp);
  endtask
  // stop first, then change the clock code, as software must
  task automatic set_code(input logic [3:0] c);
    wr(ADDR_MODE_U6, 8'h00);
    wr(ADDR_CLK_LOW_U6, {5'h00, c[2:0]});
    wr(ADDR_CLK_HIGH_U6, {7'h00, c[3]});
  endtask
  // pulses are one cycle wide, so every cycle is sampled just after its edge
  task automatic wait_pulse(input logic ovf, input int bound, output int t);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    #1;
    while ((ovf ? overflow_out : match_interrupt_out) !== 1'b1) begin
      k++;
      if (k > bound) begin
        check(16'h0000, 16'h0001);
        give_verdict();
      end
      @(posedge clk_sys_in);
      #1;
    end
    t = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenario sequence
  initial begin
    repeat (2) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd_chk(ADDR_CLK_LOW_U6, CLK_SELECT_RESET);
    rd_chk(ADDR_CLK_HIGH_U6, CLK_SELECT_RESET);
    rd_chk(ADDR_MODE_U6, 8'h04);
    rd_chk(ADDR_COMPARE_U6, 8'h00);
    wr(ADDR_COUNT_U6, 8'h55);
    rd_chk(ADDR_COUNT_U6, 8'h00);
    rd_chk(32'hFFFFF288, 8'h00);
    $display("test reset done");
    // every division code, compare 1 gives two count clocks per interrupt
    for (int i = 0; i < 7; i++) begin
      set_code(codes[i]);
      wr(ADDR_COMPARE_U6, 8'h01);
      wr(ADDR_MODE_U6, 8'h80);
      wait_pulse(1'b0, 2000, t0);
      wait_pulse(1'b0, 2000, t1);
      check(16'(t1 - t0), 16'(2 * divs[i]));
    end
    wr(ADDR_MODE_U6, 8'h00);
    rd_chk(ADDR_COUNT_U6, 8'h00);
    $display("test divisions done");
    // presets, then square wave at compare 0
    set_code(CODE_DIV4);
    wr(ADDR_COMPARE_U6, 8'h00);
    wr(ADDR_MODE_U6, 8'h09);
    repeat (2) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0001);
    wr(ADDR_MODE_U6, 8'h05);
    repeat (2) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0000);
    wr(ADDR_MODE_U6, 8'h81);
    // the pin is registered from the flip-flop, so it follows the interrupt one cycle late
    wait_pulse(1'b0, 100, t0);
    repeat (2) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0001);
    wait_pulse(1'b0, 100, t1);
    repeat (2) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0000);
    check(16'(t1 - t0), 16'h0004);
    $display("test square wave done");
    // prohibited codes give no count pulses
    for (int c = 8; c < 16; c++) begin
      if (c != 10 && c != 11) begin
        set_code(4'(c));
        wr(ADDR_MODE_U6, 8'h80);
        repeat (40) @(negedge clk_sys_in);
        rd_chk(ADDR_COUNT_U6, 8'h00);
      end
    end
    // an upper cascaded timer counts the carry, not its own code; compare FFH keeps
    // the match clear out of the way
    wr(ADDR_COMPARE_U6, 8'hFF);
    wr(ADDR_MODE_U6, 8'h90);
    repeat (3) begin
      @(negedge clk_sys_in);
      cascade_tick_in = 1'b1;
      @(negedge clk_sys_in);
      cascade_tick_in = 1'b0;
    end
    rd_chk(ADDR_COUNT_U6, 8'h03);
    $display("test prohibited and cascade done");
    // code F on unit 7: one timer zero overflow, two line sync pulses
    wr(ADDR_CLK_LOW_U7, 8'h07);
    wr(ADDR_CLK_HIGH_U7, 8'h01);
    wr(ADDR_COMPARE_U7, 8'hFF);
    wr(ADDR_MODE_U7, 8'h80);
    @(negedge clk_sys_in);
    ref_ovf = 1'b1;
    @(negedge clk_sys_in);
    ref_ovf = 1'b0;
    repeat (2) begin
      line_sync = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      line_sync = 1'b0;
      repeat (6) @(negedge clk_sys_in);
    end
    rd7_chk(ADDR_COUNT_U7, 16'h0201);
    $display("test unit 7 sources done");
    // event pin edges both ways, then sub clock
    wr(ADDR_COMPARE_U6, 8'hFF);
    for (int e = 0; e < 3; e++) begin
      set_code(e == 2 ? CODE_SEVEN : 4'(e));
      wr(ADDR_MODE_U6, 8'h80);
      i_pins.burst(5 - e, e == 2);
      repeat (10) @(negedge clk_sys_in);
      rd_chk(ADDR_COUNT_U6, 8'(5 - e));
    end
    $display("test events done");
    // pwm, active high, compare 10H, so 11H count clocks wide; overflow period is 256 count clocks
    set_code(CODE_DIV4);
    wr(ADDR_COMPARE_U6, 8'h10);
    pwm_watch = 1'b1;
    wr(ADDR_MODE_U6, 8'hC3);
    repeat (500) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0000);
    wait_pulse(1'b1, 1200, t0);
    repeat (3) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0001);
    repeat (80) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0000);
    wait_pulse(1'b1, 1200, t1);
    check(16'(t1 - t0), 16'd1024);
    wr(ADDR_MODE_U6, 8'h43);
    repeat (3) @(negedge clk_sys_in);
    check({15'h0, timer_output_pin_out}, 16'h0000);
    pwm_watch = 1'b0;
    check(16'(irq_in_pwm), 16'h0000);
    $display("test pwm done");
    give_verdict();
  end
endmodule
